// ---- hw/gp_control_regs.sv ----
// Purpose: radio wake control, crypto memory base, led control and fine count snapshot
// Assumes: one-cycle strobes, read data one cycle after the read strobe
// Notes: event status clears on read, a same-cycle event survives the clear
`timescale 1ns/1ps

// Notes on behaviour
// - general control bit 2 reads the present level of the radio wake interrupt.
// - the bridge skip bit routes radio accesses around the bridge, for 16MHz crystal use only.
// - a wake request in deep sleep raises the wake interrupt 3 to 4 low-power cycles later.
// - the 7-bit base field places the crypto memory in 1KB pages within a 128KB range.
// - the 2KB crypto window wraps from the top to the bottom of the range at page 0x7F.
// - the four trim bits 9:6 set the led driver current trim.
// - output one is enabled by bit 3 and takes pwm_a or the breathing timer by bit 0.
// - output two is enabled by bit 4 and takes pwm_b or the breathing timer by bit 1.
// - output three is enabled by bit 5 and takes pwm_c or the breathing timer by bit 2.
// - pwm_a, pwm_b and pwm_c also reach pins through pin functions 25, 26 and 27.
// - the snapshot keeps the radio fine counter captured at sleep entry.
// - at wake-up the snapshot is loaded back into the radio fine counter.
// - while the radio sleeps software reads and replaces the snapshot.
// - while the radio is awake a snapshot write does not disturb the radio.
module gp_control_regs
   import gp_ctrl_pkg::*;
#(
   parameter int FINE_W = FINE_COUNT_WIDTH
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire reg_bus_req_type bus_req,
   output logic [15:0] bus_rdata,
   input wire logic lp_clk,
   input wire logic radio_sleep_entry,
   input wire logic [FINE_W-1:0] radio_fine_counter,
   input wire logic pwm_a,
   input wire logic pwm_b,
   input wire logic pwm_c,
   input wire logic breath_out,
   input wire logic [10:0] crypto_local_addr,
   input wire logic [4:0] gpio_func_id,
   output logic radio_wake_request,
   output logic radio_wake_lp_irq,
   output logic radio_bus_bridge_skip,
   output logic radio_sleeping,
   output logic [FINE_W-1:0] fine_count_restore_value,
   output logic fine_count_restore_load,
   output logic [16:0] crypto_mem_addr,
   output led_drive_type led_drive,
   output logic gpio_func_out,
   output logic irq
);

   function automatic logic hit(input logic [31:0] addr, input logic [31:0] offset);
      hit = (addr == offset);
   endfunction

   // registers
   logic wake_req;
   logic bridge_skip;
   logic [6:0] crypto_base_page;
   light_ctrl_type light_ctrl;
   logic [FINE_W-1:0] snapshot;
   logic [2:0] event_status;
   logic [2:0] event_mask;

   // sequencer outputs
   logic seq_sleeping;
   logic seq_capture;
   logic seq_restore;
   logic seq_wake_irq;
   logic wake_irq_prev;

   radio_wake_sequencer u_wake_seq (
      .sys_clk(sys_clk),
      .reset(reset),
      .lp_clk(lp_clk),
      .wake_request(wake_req),
      .sleep_entry(radio_sleep_entry),
      .sleeping(seq_sleeping),
      .capture_pulse(seq_capture),
      .restore_pulse(seq_restore),
      .wake_lp_irq(seq_wake_irq)
   );

   // address decode
   wire sel_gen = hit(bus_req.addr, GENERAL_CONTROL_OFFSET);
   wire sel_base = hit(bus_req.addr, CRYPTO_MEMORY_BASE_OFFSET);
   wire sel_led = hit(bus_req.addr, LIGHT_DRIVER_CONTROL_OFFSET);
   wire sel_snap = hit(bus_req.addr, RADIO_FINE_COUNT_SAVE_OFFSET);
   wire sel_stat = hit(bus_req.addr, EVENT_STATUS_OFFSET);
   wire sel_mask = hit(bus_req.addr, EVENT_MASK_OFFSET);

   wire wr_gen = bus_req.wr & sel_gen;
   wire wr_base = bus_req.wr & sel_base;
   wire wr_led = bus_req.wr & sel_led;
   wire wr_snap = bus_req.wr & sel_snap;
   wire wr_mask = bus_req.wr & sel_mask;
   wire rd_stat = bus_req.rd & sel_stat;

   // read data, reserved bits zero, unmapped reads zero
   wire [15:0] gen_view = {13'h0000, seq_wake_irq, bridge_skip, wake_req};
   wire [15:0] base_view = {9'h000, crypto_base_page};
   wire [15:0] led_view = {6'h00, light_ctrl};
   wire [15:0] snap_view = {{(16 - FINE_W){1'b0}}, snapshot};
   wire [15:0] stat_view = {13'h0000, event_status};
   wire [15:0] mask_view = {13'h0000, event_mask};
   wire [15:0] next_rdata = !bus_req.rd ? 16'h0000 :
                            sel_gen ? gen_view :
                            sel_base ? base_view :
                            sel_led ? led_view :
                            sel_snap ? snap_view :
                            sel_stat ? stat_view :
                            sel_mask ? mask_view : 16'h0000;

   // events: set wins over read clear
   wire [2:0] events = {seq_restore, seq_capture, seq_wake_irq & ~wake_irq_prev};
   wire [2:0] next_status = (rd_stat ? 3'h0 : event_status) | events;
   wire next_irq = |(next_status & event_mask);

   // snapshot: hardware capture wins over a software write
   wire [FINE_W-1:0] next_snapshot = seq_capture ? radio_fine_counter :
                                     wr_snap ? bus_req.wdata[FINE_W-1:0] : snapshot;

   // crypto window: 17-bit sum wraps page 0x7f back to address zero
   wire [16:0] page_base = {crypto_base_page, 10'h000};
   wire [16:0] next_crypto_addr = page_base + {6'h00, crypto_local_addr};

   // led drive selection
   wire next_on_a = light_ctrl.en_a & (light_ctrl.src_a ? breath_out : pwm_a);
   wire next_on_b = light_ctrl.en_b & (light_ctrl.src_b ? breath_out : pwm_b);
   wire next_on_c = light_ctrl.en_c & (light_ctrl.src_c ? breath_out : pwm_c);

   // pin function routing, independent of the led selection
   wire next_gpio_func = (gpio_func_id == PIN_FUNC_PWM_A) ? pwm_a :
                         (gpio_func_id == PIN_FUNC_PWM_B) ? pwm_b :
                         (gpio_func_id == PIN_FUNC_PWM_C) ? pwm_c : 1'b0;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wake_req <= GENERAL_CONTROL_RESET[WAKE_REQUEST_BIT];
         bridge_skip <= GENERAL_CONTROL_RESET[BRIDGE_SKIP_BIT];
         crypto_base_page <= CRYPTO_BASE_RESET;
         light_ctrl <= LIGHT_DRIVER_RESET;
      end else begin
         if (wr_gen) begin
            wake_req <= bus_req.wdata[WAKE_REQUEST_BIT];
            bridge_skip <= bus_req.wdata[BRIDGE_SKIP_BIT];
         end
         if (wr_base) begin
            crypto_base_page <= bus_req.wdata[PAGE_WIDTH-1:0];
         end
         if (wr_led) begin
            light_ctrl <= bus_req.wdata[LED_FIELD_WIDTH-1:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         snapshot <= FINE_COUNT_RESET;
         event_status <= EVENT_RESET;
         event_mask <= EVENT_RESET;
         wake_irq_prev <= 1'b0;
      end else begin
         snapshot <= next_snapshot;
         event_status <= next_status;
         wake_irq_prev <= seq_wake_irq;
         if (wr_mask) begin
            event_mask <= bus_req.wdata[EVENT_COUNT-1:0];
         end
      end
   end

   // output flops
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bus_rdata <= 16'h0000;
         irq <= 1'b0;
      end else begin
         bus_rdata <= next_rdata;
         irq <= next_irq;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         radio_wake_request <= 1'b0;
         radio_wake_lp_irq <= 1'b0;
         radio_bus_bridge_skip <= 1'b0;
         radio_sleeping <= 1'b0;
         fine_count_restore_value <= FINE_COUNT_RESET;
         fine_count_restore_load <= 1'b0;
      end else begin
         radio_wake_request <= wake_req;
         radio_wake_lp_irq <= seq_wake_irq;
         radio_bus_bridge_skip <= bridge_skip;
         radio_sleeping <= seq_sleeping;
         fine_count_restore_value <= snapshot;
         fine_count_restore_load <= seq_restore;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         crypto_mem_addr <= 17'h00000;
         led_drive <= 7'h00;
         gpio_func_out <= 1'b0;
      end else begin
         crypto_mem_addr <= next_crypto_addr;
         led_drive <= {light_ctrl.trim, next_on_c, next_on_b, next_on_a};
         gpio_func_out <= next_gpio_func;
      end
   end

   // assertions
   sequence s_gen_read;
      bus_req.rd && sel_gen;
   endsequence

   property p_wake_irq_live;
      @(posedge sys_clk) disable iff (reset)
      s_gen_read |=> bus_rdata[WAKE_IRQ_BIT] == $past(seq_wake_irq);
   endproperty
   a_wake_irq_live: assert property (p_wake_irq_live) else $error("wake irq bit not live");

   sequence s_skip_write;
      wr_gen ##1 1'b1;
   endsequence

   property p_bridge_skip;
      @(posedge sys_clk) disable iff (reset)
      s_skip_write |=> radio_bus_bridge_skip == $past(bus_req.wdata[BRIDGE_SKIP_BIT], 2);
   endproperty
   a_bridge_skip: assert property (p_bridge_skip) else $error("bridge skip not applied");

   property p_crypto_page;
      @(posedge sys_clk) disable iff (reset)
      ##1 crypto_mem_addr[9:0] == $past(crypto_local_addr[9:0]);
   endproperty
   a_crypto_page: assert property (p_crypto_page) else $error("crypto page offset wrong");

   property p_crypto_wrap;
      @(posedge sys_clk) disable iff (reset)
      crypto_base_page == 7'h7f && crypto_local_addr[10] |=> crypto_mem_addr[16:10] == 7'h00;
   endproperty
   a_crypto_wrap: assert property (p_crypto_wrap) else $error("crypto window did not wrap");

   property p_trim;
      @(posedge sys_clk) disable iff (reset)
      wr_led |=> ##1 led_drive.trim == $past(bus_req.wdata[9:6], 2);
   endproperty
   a_trim: assert property (p_trim) else $error("led_current_trim not applied");

   property p_led_a;
      @(posedge sys_clk) disable iff (reset)
      ##1 led_drive.on_a == $past(next_on_a) && (!$past(light_ctrl.en_a) -> !led_drive.on_a);
   endproperty
   a_led_a: assert property (p_led_a) else $error("led output one wrong");

   property p_led_b;
      @(posedge sys_clk) disable iff (reset)
      light_ctrl.en_b && !light_ctrl.src_b |=> led_drive.on_b == $past(pwm_b);
   endproperty
   a_led_b: assert property (p_led_b) else $error("led output two wrong");

   property p_led_c;
      @(posedge sys_clk) disable iff (reset)
      light_ctrl.en_c && light_ctrl.src_c |=> led_drive.on_c == $past(breath_out);
   endproperty
   a_led_c: assert property (p_led_c) else $error("led output three wrong");

   property p_pin_func;
      @(posedge sys_clk) disable iff (reset)
      gpio_func_id == PIN_FUNC_PWM_B |=> gpio_func_out == $past(pwm_b);
   endproperty
   a_pin_func: assert property (p_pin_func) else $error("pin function pwm wrong");

   property p_capture;
      @(posedge sys_clk) disable iff (reset)
      seq_capture |=> snapshot == $past(radio_fine_counter);
   endproperty
   a_capture: assert property (p_capture) else $error("snapshot not captured");

   sequence s_restore;
      seq_restore ##1 fine_count_restore_load;
   endsequence

   property p_restore;
      @(posedge sys_clk) disable iff (reset)
      seq_restore |-> s_restore ##0 fine_count_restore_value == $past(snapshot);
   endproperty
   a_restore: assert property (p_restore) else $error("restore value wrong");

   property p_sleep_write;
      @(posedge sys_clk) disable iff (reset)
      wr_snap && seq_sleeping && !seq_capture |=> snapshot == $past(bus_req.wdata[9:0]);
   endproperty
   a_sleep_write: assert property (p_sleep_write) else $error("sleep write lost");

   property p_awake_write;
      @(posedge sys_clk) disable iff (reset)
      wr_snap && !seq_sleeping |=> fine_count_restore_load == $past(seq_restore)
         && seq_sleeping == $past(radio_sleep_entry);
   endproperty
   a_awake_write: assert property (p_awake_write) else $error("awake write disturbed radio");

   property p_reserved;
      @(posedge sys_clk) disable iff (reset)
      bus_req.rd && sel_led |=> bus_rdata[15:10] == 6'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

   property p_rdata_idle;
      @(posedge sys_clk) disable iff (reset)
      !bus_req.rd |=> bus_rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("idle read data not zero");

   property p_unmapped;
      @(posedge sys_clk) disable iff (reset)
      bus_req.rd && !(sel_gen || sel_base || sel_led || sel_snap || sel_stat || sel_mask)
         |=> bus_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_gen_reserved;
      @(posedge sys_clk) disable iff (reset)
      s_gen_read |=> bus_rdata[15:3] == 13'h0000;
   endproperty
   a_gen_reserved: assert property (p_gen_reserved) else $error("control spare bits set");

   property p_set_wins;
      @(posedge sys_clk) disable iff (reset)
      |events |=> (event_status & $past(events)) == $past(events);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost to status clear");

   property p_wake_out;
      @(posedge sys_clk) disable iff (reset)
      wr_gen |=> ##1 radio_wake_request == $past(bus_req.wdata[WAKE_REQUEST_BIT], 2);
   endproperty
   a_wake_out: assert property (p_wake_out) else $error("wake request not driven");

   property p_irq_level;
      @(posedge sys_clk) disable iff (reset)
      ##1 irq == |(event_status & $past(event_mask));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq not status and mask");

endmodule

// ---- hw/gp_ctrl_pkg.sv ----
// Purpose: constants and carrier types for the general-purpose control register subset
// Assumes: 16-bit register data, byte addresses as printed on the processor bus
// Notes: interrupt status and mask sit in an otherwise unused slot of the map
package gp_ctrl_pkg;

   localparam int ADDR_WIDTH = 32;
   localparam int DATA_WIDTH = 16;

   // register byte addresses
   localparam logic [31:0] GENERAL_CONTROL_OFFSET = 32'h5000_3308;
   localparam logic [31:0] CRYPTO_MEMORY_BASE_OFFSET = 32'h5000_330a;
   localparam logic [31:0] LIGHT_DRIVER_CONTROL_OFFSET = 32'h5000_330c;
   localparam logic [31:0] RADIO_FINE_COUNT_SAVE_OFFSET = 32'h5000_330e;
   localparam logic [31:0] EVENT_STATUS_OFFSET = 32'h5000_3340;
   localparam logic [31:0] EVENT_MASK_OFFSET = 32'h5000_3342;

   // general_control fields
   localparam int WAKE_REQUEST_BIT = 0;
   localparam int BRIDGE_SKIP_BIT = 1;
   localparam int WAKE_IRQ_BIT = 2;
   localparam logic [1:0] GENERAL_CONTROL_RESET = 2'h0;

   // crypto_memory_base fields
   localparam int PAGE_WIDTH = 7;
   localparam int PAGE_SHIFT = 10;
   localparam int CRYPTO_WINDOW_WIDTH = 11;
   localparam int CRYPTO_SPACE_WIDTH = 17;
   localparam logic [6:0] CRYPTO_BASE_RESET = 7'h00;

   // light_driver_control fields
   localparam int LED_FIELD_WIDTH = 10;
   localparam int TRIM_LSB = 6;
   localparam logic [9:0] LIGHT_DRIVER_RESET = 10'h000;

   // radio fine counter snapshot
   localparam int FINE_COUNT_WIDTH = 10;
   localparam logic [9:0] FINE_COUNT_RESET = 10'h000;

   // interrupt events
   localparam int EVENT_COUNT = 3;
   localparam int EV_WAKE_IRQ = 0;
   localparam int EV_SNAPSHOT_TAKEN = 1;
   localparam int EV_SNAPSHOT_RESTORED = 2;
   localparam logic [2:0] EVENT_RESET = 3'h0;

   // wake-up delay in low-power clock rising edges after the request is seen
   // fourth edge keeps the delay at 3 to 4 lp periods for any request phase
   localparam logic [2:0] WAKE_LP_EDGES = 3'h4;

   // pin function identifiers of the three pwm outputs
   localparam logic [4:0] PIN_FUNC_PWM_A = 5'h19;
   localparam logic [4:0] PIN_FUNC_PWM_B = 5'h1a;
   localparam logic [4:0] PIN_FUNC_PWM_C = 5'h1b;

   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_bus_req_type;

   typedef struct packed {
      logic [3:0] trim;
      logic en_c;
      logic en_b;
      logic en_a;
      logic src_c;
      logic src_b;
      logic src_a;
   } light_ctrl_type;

   typedef struct packed {
      logic [3:0] trim;
      logic on_c;
      logic on_b;
      logic on_a;
   } led_drive_type;

endpackage

// ---- hw/radio_wake_sequencer.sv ----
// Purpose: radio sleep and wake sequencing paced by the low-power clock
// Assumes: lp_clk is a slow level sampled synchronously to sys_clk
// Notes: the wake interrupt stays high until the wake request is dropped
`timescale 1ns/1ps
module radio_wake_sequencer
   import gp_ctrl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic lp_clk,
   input wire logic wake_request,
   input wire logic sleep_entry,
   output logic sleeping,
   output logic capture_pulse,
   output logic restore_pulse,
   output logic wake_lp_irq
);

   typedef enum logic [1:0] {st_awake, st_asleep, st_waking} wake_state_type;

   wake_state_type state;
   logic lp_prev;
   logic [2:0] lp_edges;
   wire lp_rise = lp_clk & ~lp_prev;
   wire wake_done = (state == st_waking) && lp_rise && (lp_edges == WAKE_LP_EDGES - 3'h1);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= st_awake;
         lp_prev <= 1'b0;
         lp_edges <= 3'h0;
         sleeping <= 1'b0;
         capture_pulse <= 1'b0;
         restore_pulse <= 1'b0;
         wake_lp_irq <= 1'b0;
      end else begin
         lp_prev <= lp_clk;
         capture_pulse <= 1'b0;
         restore_pulse <= 1'b0;
         unique case (state)
            st_awake: begin
               if (sleep_entry) begin
                  state <= st_asleep;
                  sleeping <= 1'b1;
                  capture_pulse <= 1'b1;
               end
            end
            st_asleep: begin
               // request is trusted to stay high one sys_clk cycle
               if (wake_request) begin
                  state <= st_waking;
                  lp_edges <= 3'h0;
               end
            end
            st_waking: begin
               if (lp_rise) begin
                  lp_edges <= lp_edges + 3'h1;
               end
               if (wake_done) begin
                  state <= st_awake;
                  sleeping <= 1'b0;
                  wake_lp_irq <= 1'b1;
                  restore_pulse <= 1'b1;
               end
            end
         endcase
         if (!wake_request && state != st_waking) begin
            wake_lp_irq <= 1'b0;
         end
      end
   end

   // lp edges counted since the sequencer entered waking
   logic [2:0] seen_edges;
   always_ff @(posedge sys_clk) begin
      if (reset || state != st_waking) begin
         seen_edges <= 3'h0;
      end else if (lp_rise && seen_edges != 3'h7) begin
         seen_edges <= seen_edges + 3'h1;
      end
   end

   property p_wake_delay;
      @(posedge sys_clk) disable iff (reset)
      $rose(wake_lp_irq) |-> $past(seen_edges) == 3'h3 && $past(lp_rise);
   endproperty
   a_wake_delay: assert property (p_wake_delay) else $error("wake irq not on fourth lp edge");

endmodule

// ---- test/radio_core_model.sv ----
// Purpose: radio core stand-in: low-power clock, fine counter, sleep entry
// Assumes: fine counter stops at sleep entry and is reloaded by the restore pulse
// Notes: low-power clock runs free, period 2*LP_HALF sys_clk cycles
`timescale 1ns/1ps
module radio_core_model #(
   parameter int LP_HALF = 8
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic sleep_cmd,
   input wire logic [9:0] fine_count_restore_value,
   input wire logic fine_count_restore_load,
   output logic lp_clk,
   output logic radio_sleep_entry,
   output logic [9:0] radio_fine_counter
);
   int lp_cnt;
   logic frozen;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         lp_cnt <= 0;
         lp_clk <= 1'b0;
         radio_sleep_entry <= 1'b0;
         radio_fine_counter <= 10'h000;
         frozen <= 1'b0;
      end else begin
         lp_cnt <= (lp_cnt == LP_HALF - 1) ? 0 : lp_cnt + 1;
         if (lp_cnt == LP_HALF - 1) begin
            lp_clk <= ~lp_clk;
         end
         radio_sleep_entry <= sleep_cmd && !frozen;
         if (fine_count_restore_load) begin
            radio_fine_counter <= fine_count_restore_value;
            frozen <= 1'b0;
         end else if (sleep_cmd) begin
            frozen <= 1'b1;
         end else if (!frozen) begin
            radio_fine_counter <= radio_fine_counter + 10'h001;
         end
      end
   end
endmodule

// ---- test/testbench.sv ----
// Purpose: self-checking bench for the general-purpose control register subset
// Assumes: radio_core_model stands in for the radio core
// Notes: low-power clock period is LP sys_clk cycles
`timescale 1ns/1ps
module testbench
   import gp_ctrl_pkg::*;
   ;
   localparam int LP = 16;
   logic sys_clk;
   logic reset;
   reg_bus_req_type bus_req;
   logic [15:0] bus_rdata;
   logic lp_clk, radio_sleep_entry, sleep_cmd, pwm_a, pwm_b, pwm_c, breath_out;
   logic radio_wake_request, radio_wake_lp_irq, radio_bus_bridge_skip, radio_sleeping;
   logic fine_count_restore_load, gpio_func_out, irq;
   logic [9:0] radio_fine_counter, fine_count_restore_value;
   logic [10:0] crypto_local_addr;
   logic [4:0] gpio_func_id;
   logic [16:0] crypto_mem_addr;
   led_drive_type led_drive;
   int error_cnt = 0;
   int samples_checked = 0;
   logic [31:0] reg_addr [4] = '{GENERAL_CONTROL_OFFSET, CRYPTO_MEMORY_BASE_OFFSET,
      LIGHT_DRIVER_CONTROL_OFFSET, RADIO_FINE_COUNT_SAVE_OFFSET};

   gp_control_regs i_dut (
      .sys_clk(sys_clk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .lp_clk(lp_clk), .radio_sleep_entry(radio_sleep_entry),
      .radio_fine_counter(radio_fine_counter), .pwm_a(pwm_a), .pwm_b(pwm_b), .pwm_c(pwm_c),
      .breath_out(breath_out), .crypto_local_addr(crypto_local_addr),
      .gpio_func_id(gpio_func_id), .radio_wake_request(radio_wake_request),
      .radio_wake_lp_irq(radio_wake_lp_irq), .radio_bus_bridge_skip(radio_bus_bridge_skip),
      .radio_sleeping(radio_sleeping), .fine_count_restore_value(fine_count_restore_value),
      .fine_count_restore_load(fine_count_restore_load), .crypto_mem_addr(crypto_mem_addr),
      .led_drive(led_drive), .gpio_func_out(gpio_func_out), .irq(irq)
   );

   radio_core_model #(.LP_HALF(LP / 2)) i_model (
      .sys_clk(sys_clk), .reset(reset), .sleep_cmd(sleep_cmd),
      .fine_count_restore_value(fine_count_restore_value),
      .fine_count_restore_load(fine_count_restore_load), .lp_clk(lp_clk),
      .radio_sleep_entry(radio_sleep_entry), .radio_fine_counter(radio_fine_counter)
   );

   task automatic print_verdict();
      $display("compared %0d, mismatched %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic timed_out();
      error_cnt++;
      $display("wait limit reached at %0t", $time);
      print_verdict();
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   task automatic reg_wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic reg_chk(input logic [31:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1;
      check({16'h0000, bus_rdata}, {16'h0000, exp});
   endtask

   task automatic wait_lp(input logic lvl);
      int n = 0;
      while (lp_clk !== lvl) begin
         @(posedge sys_clk);
         n++;
         if (n > 4 * LP) timed_out();
      end
   endtask

   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         reg_chk(reg_addr[i], 16'h0000);
      end
      reg_chk(EVENT_STATUS_OFFSET, 16'h0000);
      reg_chk(EVENT_MASK_OFFSET, 16'h0000);
      reg_wr(32'h5000_3310, 16'hffff);
      reg_chk(32'h5000_3310, 16'h0000);
      check(led_drive, 7'h00);
      check(irq, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_reserved();
      logic [15:0] m [4] = '{16'h0003, 16'h007f, 16'h03ff, 16'h03ff};
      for (int i = 0; i < 4; i++) begin
         reg_wr(reg_addr[i], 16'hffff);
         reg_chk(reg_addr[i], m[i]);
      end
      check(radio_bus_bridge_skip, 1'b1);
      check(radio_wake_request, 1'b1);
      check(radio_wake_lp_irq, 1'b0);
      for (int i = 0; i < 4; i++) begin
         reg_wr(reg_addr[i], 16'h0000);
      end
      settle();
      check(radio_bus_bridge_skip, 1'b0);
      $display("test reserved done");
   endtask

   task automatic t_led();
      logic [9:0] v [4] = '{10'h038, 10'h07f, 10'h3ce, 10'h155};
      logic [6:0] e;
      @(posedge sys_clk);
      {pwm_c, pwm_b, pwm_a} <= 3'b101;
      for (int b = 0; b < 2; b++) begin
         for (int i = 0; i < 4; i++) begin
            reg_wr(LIGHT_DRIVER_CONTROL_OFFSET, {6'h00, v[i]});
            breath_out <= b[0];
            settle();
            e = {v[i][9:6], v[i][5] & (v[i][2] ? b[0] : 1'b1),
               v[i][4] & (v[i][1] ? b[0] : 1'b0), v[i][3] & (v[i][0] ? b[0] : 1'b1)};
            check(led_drive, e);
         end
      end
      $display("test led done");
   endtask

   task automatic t_crypto();
      logic [6:0] pg [6] = '{7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h03, 7'h00};
      logic [10:0] la [6] = '{11'h000, 11'h3ff, 11'h400, 11'h7ff, 11'h7ff, 11'h123};
      logic [16:0] ex [6] = '{17'h1fc00, 17'h1ffff, 17'h00000, 17'h003ff, 17'h013ff,
         17'h00123};
      for (int i = 0; i < 6; i++) begin
         reg_wr(CRYPTO_MEMORY_BASE_OFFSET, {9'h000, pg[i]});
         crypto_local_addr <= la[i];
         settle();
         check(crypto_mem_addr, ex[i]);
      end
      $display("test crypto done");
   endtask

   task automatic t_gpio();
      for (int k = 0; k < 3; k++) begin
         for (int id = 24; id < 29; id++) begin
            @(posedge sys_clk);
            {pwm_c, pwm_b, pwm_a} <= 3'b001 << k;
            gpio_func_id <= id[4:0];
            settle();
            check(gpio_func_out, id == 25 + k);
         end
      end
      $display("test gpio done");
   endtask

   task automatic t_wake();
      int n;
      reg_wr(EVENT_MASK_OFFSET, 16'h0000);
      @(posedge sys_clk);
      sleep_cmd <= 1'b1;
      @(posedge sys_clk);
      sleep_cmd <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      check(radio_sleeping, 1'b1);
      check(irq, 1'b0);
      reg_chk(RADIO_FINE_COUNT_SAVE_OFFSET, {6'h00, radio_fine_counter});
      reg_wr(RADIO_FINE_COUNT_SAVE_OFFSET, 16'hfd55);
      reg_chk(RADIO_FINE_COUNT_SAVE_OFFSET, 16'h0155);
      reg_wr(EVENT_MASK_OFFSET, 16'h0007);
      settle();
      check(irq, 1'b1);
      wait_lp(1'b0);
      wait_lp(1'b1);
      reg_wr(GENERAL_CONTROL_OFFSET, 16'h0001);
      n = 0;
      #1;
      while (radio_wake_lp_irq !== 1'b1) begin
         @(posedge sys_clk);
         #1;
         n++;
         if (n > 6 * LP) timed_out();
      end
      check(n >= 3 * LP && n <= 4 * LP + 4, 1'b1);
      check(fine_count_restore_load, 1'b1);
      check(fine_count_restore_value, 10'h155);
      @(posedge sys_clk);
      #1;
      check(radio_fine_counter, 10'h155);
      check(radio_sleeping, 1'b0);
      reg_chk(GENERAL_CONTROL_OFFSET, 16'h0005);
      reg_chk(EVENT_STATUS_OFFSET, 16'h0007);
      reg_chk(EVENT_STATUS_OFFSET, 16'h0000);
      settle();
      check(irq, 1'b0);
      reg_wr(GENERAL_CONTROL_OFFSET, 16'h0000);
      settle();
      reg_chk(GENERAL_CONTROL_OFFSET, 16'h0000);
      reg_wr(RADIO_FINE_COUNT_SAVE_OFFSET, 16'h00aa);
      n = 0;
      repeat (8) begin
         @(posedge sys_clk);
         #1;
         if (fine_count_restore_load === 1'b1) n++;
      end
      check(n, 0);
      check(radio_sleeping, 1'b0);
      $display("test wake done");
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   initial begin
      reset = 1'b1;
      bus_req = '0;
      sleep_cmd = 1'b0;
      {pwm_a, pwm_b, pwm_c, breath_out} = 4'h0;
      crypto_local_addr = 11'h000;
      gpio_func_id = 5'h00;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_reserved();
      t_led();
      t_crypto();
      t_gpio();
      t_wake();
      print_verdict();
   end
endmodule
